// *** word_cmp_defs.svh ***
// word_cmp_defs.svh: bus offsets, field positions and reset values
// assumes: included by the package and the comparator top
`ifndef WORD_CMP_DEFS_SVH
`define WORD_CMP_DEFS_SVH

`define CTRL_ADDR        4'h0
`define STAT_ADDR        4'h4
`define OPA_ADDR         4'h8
`define OPB_ADDR         4'hc
`define CTRL_CLEAR_BIT   0
`define CTRL_MSB_BIT     1
`define CTRL_SIGNED_BIT  2
`define CTRL_RESET       32'h0000_0000
`define WORD_RESET       8'h00
`define SLICE_WIDTH      8

`endif

// *** word_cmp_pkg.sv ***
// word_cmp_pkg.sv: types shared by the comparator files
// assumes: word_cmp_defs.svh sits in the same folder
`include "word_cmp_defs.svh"

package word_cmp_pkg;

    typedef enum logic [3:0] {
        OP_HOLD  = 4'b0001,
        OP_SHIFT = 4'b0010,
        OP_LOAD  = 4'b0100,
        OP_READ  = 4'b1000
    } reg_op_t;

    typedef struct packed {
        logic mismatch;
        logic greater;
        logic differ;
    } serial_flags_t;

    typedef struct packed {
        logic less;
        logic greater;
        logic equal;
    } mag_result_t;

endpackage

// *** cmp_slice.sv ***
// cmp_slice.sv: one register slice with magnitude comparator and cascade
// assumes: driven by the comparator top on the same clock
`timescale 1ns/1ps
`include "word_cmp_defs.svh"

module cmp_slice
    import word_cmp_pkg::*;
#(
    parameter int WIDTH = `SLICE_WIDTH
) (
    input  wire logic             clk_i,
    input  wire logic             nrst_i,
    input  wire logic             op_select_low_i,
    input  wire logic             op_select_high_i,
    input  wire logic             signed_mode_i,
    input  wire logic             status_out_enable_n_i,
    input  wire logic             cascade_in_i,
    input  wire logic             shift_in_i,
    input  wire logic [WIDTH-1:0] load_word_i,
    input  wire logic [WIDTH-1:0] port_word_i,
    output logic      [WIDTH-1:0] held_word_o,
    output logic                  cascade_out_o,
    output mag_result_t           result_o,
    output mag_result_t           result_oe_o
);

    logic [WIDTH-1:0] held;
    logic [WIDTH-1:0] next_held;
    reg_op_t          op;
    logic             gt;
    logic             eq;

    always_comb begin
        case ({op_select_high_i, op_select_low_i})
            2'b00:   op = OP_HOLD;
            2'b01:   op = OP_SHIFT;
            2'b10:   op = OP_READ;
            default: op = OP_LOAD;
        endcase
    end

    always_comb begin
        case (op)
            OP_LOAD:  next_held = load_word_i;
            OP_SHIFT: next_held = {held[WIDTH-2:0], shift_in_i};
            default:  next_held = held;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            held <= '0;
        end else begin
            held <= next_held;
        end
    end

    // signed compare just flips the sign bit of both operands
    always_comb begin
        eq = (held == port_word_i);
        if (signed_mode_i) begin
            gt = {~held[WIDTH-1], held[WIDTH-2:0]} >
                 {~port_word_i[WIDTH-1], port_word_i[WIDTH-2:0]};
        end else begin
            gt = held > port_word_i;
        end
    end

    // wired outputs: drive only enables, never a floating driver
    always_comb begin
        held_word_o       = held;
        cascade_out_o     = cascade_in_i & eq;
        result_o.greater  = gt;
        result_o.less     = ~gt & ~eq;
        result_o.equal    = eq;
        // a slice speaks only while the chain above it reports equal
        result_oe_o.greater = cascade_in_i & ~eq;
        result_oe_o.less    = cascade_in_i & ~eq;
        // equality shows only on the enabled (least significant) slice
        result_oe_o.equal   = cascade_in_i & eq &
                              ~status_out_enable_n_i;
    end

endmodule // cmp_slice

// *** word_comparator.sv ***
// word_comparator.sv: serial and parallel comparators behind wishbone
// assumes: classic wishbone master on clk_i; serial bits come as pins
//
// Implementation choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "word_cmp_defs.svh"

module word_comparator
    import word_cmp_pkg::*;
#(
    parameter int WIDTH  = `SLICE_WIDTH,
    parameter int SLICES = 3
) (
    input  wire logic               clk_i,
    input  wire logic               nrst_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [3:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic               serial_a_i,
    input  wire logic               serial_b_i,
    input  wire logic               serial_clk_i,
    input  wire logic               serial_clear_i,
    input  wire logic               op_select_low_i,
    input  wire logic               op_select_high_i,
    input  wire logic               status_out_enable_n_i,
    input  wire logic               cascade_in_i,
    input  wire logic [SLICES*WIDTH-1:0] port_word_i,
    input  wire logic [SLICES*WIDTH-1:0] port_word_out_unused_i,
    output logic      [SLICES*WIDTH-1:0] port_word_o,
    output logic      [SLICES*WIDTH-1:0] port_word_oe_o,
    output logic                    mismatch_o,
    output logic                    greater_flag_o,
    output logic                    differ_flag_o,
    output logic                    parallel_equal_o,
    output logic                    greater_out_o,
    output logic                    less_out_o,
    output logic                    equal_out_o,
    output logic                    greater_out_oe_o,
    output logic                    less_out_oe_o,
    output logic                    equal_out_oe_o
);

    localparam int NW = SLICES * WIDTH;

    // three-stage pin synchronisers; first stage feeds only the second
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sync3;
    logic [4:0] pins;
    logic [4:0] pins_q;
    logic [4:0] next_pins_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1  <= '0;
            sync2  <= '0;
            sync3  <= '0;
            pins_q <= '0;
        end else begin
            sync1  <= {serial_clear_i, serial_clk_i, serial_b_i, serial_a_i,
                       cascade_in_i};
            sync2  <= sync1;
            sync3  <= sync2;
            pins_q <= next_pins_q;
        end
    end

    // a pin change is accepted once stages two and three agree
    always_comb begin
        next_pins_q = pins_q;
        for (int i = 0; i < 5; i++) begin
            if (sync2[i] == sync3[i]) begin
                next_pins_q[i] = sync2[i];
            end
        end
        pins = next_pins_q;
    end

    logic bit_a;
    logic bit_b;
    logic bit_strobe;
    logic pin_clear;
    logic cascade_top;
    logic [4:0] pins_prev;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            pins_prev <= '0;
        end else begin
            pins_prev <= pins;
        end
    end

    assign cascade_top = pins[0];
    assign bit_a       = pins[1];
    assign bit_b       = pins[2];
    assign bit_strobe  = pins[3] & ~pins_prev[3];
    assign pin_clear   = pins[4];

    // software registers
    logic [31:0]   ctrl;
    logic [31:0]   next_ctrl;
    logic [NW-1:0] opa;
    logic [NW-1:0] next_opa;
    logic [NW-1:0] opb;
    logic [NW-1:0] next_opb;
    logic          ack;
    logic          next_ack;
    logic [31:0]   rdata;
    logic [31:0]   next_rdata;
    logic          sw_clear;
    logic          msb_first;
    logic          bus_req;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign bus_req   = wb_cyc_i & wb_stb_i & ~ack;
    assign sw_clear  = bus_req & wb_we_i & (wb_adr_i == `CTRL_ADDR) &
                       wb_sel_i[0] & wb_dat_i[`CTRL_CLEAR_BIT];
    assign msb_first = ctrl[`CTRL_MSB_BIT];

    serial_flags_t flags;
    serial_flags_t next_flags;
    logic          par_eq;
    logic          next_par_eq;
    mag_result_t   res_q;
    mag_result_t   next_res_q;
    mag_result_t   res_oe_q;
    mag_result_t   next_res_oe_q;

    always_comb begin
        next_ctrl  = ctrl;
        next_opa   = opa;
        next_opb   = opb;
        next_ack   = bus_req;
        next_rdata = 32'h0000_0000;
        if (bus_req && wb_we_i) begin
            case (wb_adr_i)
                `CTRL_ADDR: next_ctrl = merge(ctrl, wb_dat_i, wb_sel_i)
                                        & 32'h0000_0006;
                `OPA_ADDR:  next_opa  = NW'(merge(32'(opa), wb_dat_i,
                                                  wb_sel_i));
                `OPB_ADDR:  next_opb  = NW'(merge(32'(opb), wb_dat_i,
                                                  wb_sel_i));
                default:    next_ctrl = ctrl;
            endcase
        end else if (bus_req) begin
            case (wb_adr_i)
                `CTRL_ADDR: next_rdata = ctrl;
                `STAT_ADDR: next_rdata = {25'h0000000, res_q.equal,
                                          res_q.less, res_q.greater, par_eq,
                                          flags.differ, flags.greater,
                                          flags.mismatch};
                `OPA_ADDR:  next_rdata = 32'(opa);
                `OPB_ADDR:  next_rdata = 32'(opb);
                default:    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // serial flags; clear is synchronous and wins over a bit strobe in the same cycle
    always_comb begin
        next_flags = flags;
        if (sw_clear || pin_clear) begin
            next_flags = '0;
        end else if (bit_strobe) begin
            if (bit_a != bit_b) begin
                next_flags.mismatch = 1'b1;
            end
            if (!msb_first) begin
                if (bit_a && !bit_b) begin
                    next_flags.greater = 1'b1;
                end else if (!bit_a && bit_b) begin
                    next_flags.greater = 1'b0;
                end
                if (bit_a != bit_b) begin
                    next_flags.differ = 1'b1;
                end
            end else begin
                // later bits cannot move a decided outcome
                if (bit_a && !bit_b && !flags.differ) begin
                    next_flags.greater = 1'b1;
                end
                if (bit_a != bit_b) begin
                    next_flags.differ = 1'b1;
                end
            end
        end
    end

    // parallel identity: xor per bit then nor across the word
    always_comb begin
        next_par_eq = ~(|(opa ^ opb));
    end

    // cascade chain, most significant slice first
    logic [SLICES:0]      chain;
    logic [NW-1:0]        held_all;
    mag_result_t          s_res   [SLICES];
    mag_result_t          s_oe    [SLICES];

    // serial bit enters slice 0; each upper slice takes the msb below it
    logic [NW:0]          shift_bus;

    assign shift_bus     = {held_all, bit_a};
    assign chain[SLICES] = cascade_top;

    genvar g;
    generate
        for (g = 0; g < SLICES; g++) begin : g_slice
            cmp_slice #(
                .WIDTH(WIDTH)
            ) u_slice (
                .clk_i                 (clk_i),
                .nrst_i                (nrst_i),
                .op_select_low_i       (op_select_low_i),
                .op_select_high_i      (op_select_high_i),
                .signed_mode_i         (g == SLICES-1 ?
                                        ctrl[`CTRL_SIGNED_BIT] : 1'b0),
                .status_out_enable_n_i (g == 0 ?
                                        status_out_enable_n_i : 1'b1),
                .cascade_in_i          (chain[g+1]),
                .shift_in_i            (shift_bus[g*WIDTH]),
                .load_word_i           (opa[g*WIDTH +: WIDTH]),
                .port_word_i           (port_word_i[g*WIDTH +: WIDTH]),
                .held_word_o           (held_all[g*WIDTH +: WIDTH]),
                .cascade_out_o         (chain[g]),
                .result_o              (s_res[g]),
                .result_oe_o           (s_oe[g])
            );
        end
    endgenerate

    // wired join of slice results, modelled as or of enabled drivers
    always_comb begin
        next_res_q    = '0;
        next_res_oe_q = '0;
        for (int i = 0; i < SLICES; i++) begin
            next_res_oe_q = next_res_oe_q | s_oe[i];
            next_res_q    = next_res_q | (s_res[i] & s_oe[i]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl     <= `CTRL_RESET;
            opa      <= '0;
            opb      <= '0;
            ack      <= 1'b0;
            rdata    <= 32'h0000_0000;
            flags    <= '0;
            par_eq   <= 1'b1;
            res_q    <= '0;
            res_oe_q <= '0;
        end else begin
            ctrl     <= next_ctrl;
            opa      <= next_opa;
            opb      <= next_opb;
            ack      <= next_ack;
            rdata    <= next_rdata;
            flags    <= next_flags;
            par_eq   <= next_par_eq;
            res_q    <= next_res_q;
            res_oe_q <= next_res_oe_q;
        end
    end

    // read mode presents the register on the port
    logic [NW-1:0] port_q;
    logic          read_q;

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            port_q <= '0;
            read_q <= 1'b0;
        end else begin
            port_q <= held_all;
            read_q <= op_select_high_i & ~op_select_low_i;
        end
    end

    assign wb_dat_o         = rdata;
    assign wb_ack_o         = ack;
    assign port_word_o      = port_q;
    assign port_word_oe_o   = {NW{read_q}};
    assign mismatch_o       = flags.mismatch;
    assign greater_flag_o   = flags.greater;
    assign differ_flag_o    = flags.differ;
    assign parallel_equal_o = par_eq;
    assign greater_out_o    = res_q.greater;
    assign less_out_o       = res_q.less;
    assign equal_out_o      = res_q.equal;
    assign greater_out_oe_o = res_oe_q.greater;
    assign less_out_oe_o    = res_oe_q.less;
    assign equal_out_oe_o   = res_oe_q.equal;

endmodule // word_comparator

// *** word_cmp_asserts.sv ***
// word_cmp_asserts.sv: port-level assertions for the word comparator
// assumes: bound into word_comparator; one clock, low-active sync reset
`timescale 1ns/1ps
`include "word_cmp_defs.svh"

module word_cmp_asserts
    import word_cmp_pkg::*;
#(
    parameter int WIDTH  = 8,
    parameter int SLICES = 3
) (
    input wire logic                    clk_i,
    input wire logic                    nrst_i,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic                    wb_we_i,
    input wire logic [3:0]              wb_adr_i,
    input wire logic                    wb_ack_o,
    input wire logic                    serial_clk_i,
    input wire logic                    serial_clear_i,
    input wire logic                    op_select_low_i,
    input wire logic                    op_select_high_i,
    input wire logic [SLICES*WIDTH-1:0] port_word_i,
    input wire logic [SLICES*WIDTH-1:0] port_word_oe_o,
    input wire logic                    mismatch_o,
    input wire logic                    greater_flag_o,
    input wire logic                    differ_flag_o,
    input wire logic                    greater_out_o,
    input wire logic                    less_out_o,
    input wire logic                    equal_out_o
);
    logic [3:0] clr_age, next_clr_age;
    logic [3:0] stb_age, next_stb_age;
    logic       stb_seen;
    logic       clr_now;

    // any ctrl write counts as a clear: looser, but never fires falsely
    assign clr_now = serial_clear_i || (wb_cyc_i && wb_stb_i && wb_we_i
                     && wb_adr_i == `CTRL_ADDR);

    always_comb begin
        next_clr_age = clr_now ? 4'h0 : clr_age + {3'h0, clr_age != 4'hf};
        next_stb_age = stb_age + {3'h0, stb_age != 4'hf};
        if (serial_clk_i && !stb_seen) begin
            next_stb_age = 4'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        clr_age  <= nrst_i ? next_clr_age : 4'h0;
        stb_age  <= nrst_i ? next_stb_age : 4'hf;
        stb_seen <= serial_clk_i;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    a_ack_follows: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked after one cycle");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without a request");
    a_flags_agree: assert property (
        mismatch_o == differ_flag_o)
        else $error("mismatch and differ flags disagree");
    a_greater_differ: assert property (
        greater_flag_o |-> differ_flag_o)
        else $error("greater flag set without differ flag");
    a_mismatch_held: assert property (
        $fell(mismatch_o) |-> clr_age < 4'h8)
        else $error("mismatch flag dropped without a clear");
    a_differ_held: assert property (
        differ_flag_o && !clr_now && clr_age == 4'hf |=> differ_flag_o)
        else $error("differ flag dropped without a clear");
    a_differ_strobe: assert property (
        $rose(differ_flag_o) |-> stb_age >= 4'h1 && stb_age <= 4'h9)
        else $error("differ flag rose without a bit strobe");
    a_greater_strobe: assert property (
        $rose(greater_flag_o) |-> stb_age >= 4'h1 && stb_age <= 4'h9)
        else $error("greater flag rose without a bit strobe");
    a_read_drives: assert property (
        (op_select_high_i && !op_select_low_i) [*4] |-> &port_word_oe_o)
        else $error("port not driven in read mode");
    a_quiet_port: assert property (
        (!op_select_high_i) [*4] |-> port_word_oe_o == '0)
        else $error("port driven outside read mode");
    a_one_result: assert property (
        (!op_select_high_i && !op_select_low_i && $stable(port_word_i)) [*6]
        |-> $onehot({greater_out_o, less_out_o, equal_out_o}))
        else $error("settled compare result not one-hot");

    c_mismatch: cover property ($rose(mismatch_o));
    c_greater: cover property ($rose(greater_flag_o));
    c_read: cover property (&port_word_oe_o);
    c_less: cover property ($rose(less_out_o));
endmodule // word_cmp_asserts

bind word_comparator word_cmp_asserts #(
    .WIDTH(WIDTH),
    .SLICES(SLICES)
) u_asserts (
    .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_ack_o(wb_ack_o), .serial_clk_i(serial_clk_i),
    .serial_clear_i(serial_clear_i), .op_select_low_i(op_select_low_i),
    .op_select_high_i(op_select_high_i), .port_word_i(port_word_i),
    .port_word_oe_o(port_word_oe_o), .mismatch_o(mismatch_o),
    .greater_flag_o(greater_flag_o), .differ_flag_o(differ_flag_o),
    .greater_out_o(greater_out_o), .less_out_o(less_out_o),
    .equal_out_o(equal_out_o)
);

// *** serial_source.sv ***
// serial_source.sv: control logic model feeding bit pairs and clears
// assumes: its tasks are called from the bench right after a clock edge
`timescale 1ns/1ps

module serial_source (
    input  wire logic clk_i,
    output logic      bit_a_o,
    output logic      bit_b_o,
    output logic      strobe_o,
    output logic      clear_o
);
    initial begin
        bit_a_o = 1'b0;
        bit_b_o = 1'b1;
        strobe_o = 1'b0;
        clear_o = 1'b0;
    end

    // held long enough to pass the pin synchronisers
    task automatic clear_flags();
        @(posedge clk_i);
        clear_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        clear_o <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    // bits settle before the strobe; afterwards the lines show the
    // inverse so a late sample never sees a stale pair
    task automatic send_pair(input logic a, input logic b);
        @(posedge clk_i);
        bit_a_o <= a;
        bit_b_o <= b;
        repeat (5) @(posedge clk_i);
        strobe_o <= 1'b1;
        repeat (6) @(posedge clk_i);
        strobe_o <= 1'b0;
        repeat (5) @(posedge clk_i);
        bit_a_o <= ~a;
        bit_b_o <= ~b;
    endtask
endmodule // serial_source

// *** word_comparator_test.sv ***
// word_comparator_test.sv: self-checking bench for the word comparator
// assumes: serial_source and the bound checker compile alongside
`timescale 1ns/1ps
`include "word_cmp_defs.svh"

module word_comparator_test
    import word_cmp_pkg::*;
();
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        cyc, stb, we, ack;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, q;
    logic        sa, sb, sclk, sclr, opl, oph;
    logic        mis, gtf, dif, peq, gto, lto, eqo;
    logic        gtoe, ltoe, eqoe;
    logic [23:0] pw, pwo, pwoe, pdrv, pd, opa_m;
    logic [7:0]  a8, b8;
    logic [2:0]  e3;
    int          i, k, n, eg, ed, hv, pv;
    int          bad_count = 0;
    int          checks = 0;
    integer      seed = 35;

    // the shared port wire: the device wins wherever it drives
    assign pw = (pwoe & pwo) | (~pwoe & pdrv);

    word_comparator #(.WIDTH(8), .SLICES(3)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .serial_a_i(sa), .serial_b_i(sb),
        .serial_clk_i(sclk), .serial_clear_i(sclr),
        .op_select_low_i(opl), .op_select_high_i(oph),
        .status_out_enable_n_i(1'b0),
        .cascade_in_i(1'b1),
        .port_word_i(pw), .port_word_out_unused_i(24'h0),
        .port_word_o(pwo), .port_word_oe_o(pwoe), .mismatch_o(mis),
        .greater_flag_o(gtf), .differ_flag_o(dif), .parallel_equal_o(peq),
        .greater_out_o(gto), .less_out_o(lto), .equal_out_o(eqo),
        .greater_out_oe_o(gtoe), .less_out_oe_o(ltoe), .equal_out_oe_o(eqoe)
    );

    serial_source src (.clk_i(clk_i), .bit_a_o(sa), .bit_b_o(sb),
                       .strobe_o(sclk), .clear_o(sclr));

    initial forever #20 clk_i = ~clk_i;

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] r);
        int t;
        t = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack !== 1'b1 && t < 50);
        r = rdat;
        if (t >= 50) bad_count++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 4'hf, 32'h0, q);
        chk(q, e);
    endtask

    task automatic serial_word(input int msb, input int clr_bus);
        bus(1'b1, `CTRL_ADDR, 4'hf, {30'h0, msb[0], 1'b0}, q);
        if (clr_bus != 0) begin
            bus(1'b1, `CTRL_ADDR, 4'hf, {30'h0, msb[0], 1'b1}, q);
            repeat (6) @(posedge clk_i);
        end else begin
            src.clear_flags();
        end
        eg = 0;
        ed = 0;
        chk({mis, gtf, dif}, 3'h0);
        for (k = 0; k < 8; k++) begin
            n = (msb != 0) ? 7 - k : k;
            src.send_pair(a8[n], b8[n]);
            if (a8[n] != b8[n]) begin
                eg = (msb == 0 || ed == 0) ? a8[n] : eg;
                ed = 1;
            end
            chk({mis, gtf, dif}, {ed[0], eg[0], ed[0]});
        end
        chk({gtf, mis}, {a8 > b8, a8 != b8});
        bus(1'b0, `STAT_ADDR, 4'hf, 32'h0, q);
        chk(q[2:0], {ed[0], eg[0], ed[0]});
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        print_verdict();
    end

    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        sel = 4'h0;
        wdat = 32'h0;
        opl = 1'b0;
        oph = 1'b0;
        pdrv = 24'h0;
        repeat (5) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        chk({mis, gtf, dif, peq}, 4'h1);
        rd(`CTRL_ADDR, `CTRL_RESET);
        rd(`OPB_ADDR, 32'h0);
        bus(1'b1, 4'h6, 4'hf, 32'hffff_ffff, q);
        rd(4'h2, 32'h0);
        rd(`CTRL_ADDR, 32'h0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            a8 = 8'($random(seed));
            b8 = (i % 3 == 0) ? a8 : 8'($random(seed));
            if (i >= 5) b8 = a8 ^ 8'h81;
            serial_word(i % 2, i % 3 == 1);
        end
        $display("test serial done");
        for (i = 0; i < 4; i++) begin
            opa_m = 24'($random(seed));
            pd = (i % 2 == 1) ? opa_m : opa_m ^ (24'h1 << (i * 11));
            bus(1'b1, `OPA_ADDR, 4'hf, {8'h0, opa_m}, q);
            bus(1'b1, `OPB_ADDR, 4'hf, {8'h0, pd}, q);
            repeat (3) @(posedge clk_i);
            chk(peq, opa_m == pd);
        end
        bus(1'b1, `OPA_ADDR, 4'h2, 32'hffff_ffff, q);
        opa_m[15:8] = 8'hff;
        rd(`OPA_ADDR, {8'h0, opa_m});
        $display("test parallel done");
        {oph, opl} <= 2'b11;
        repeat (4) @(posedge clk_i);
        {oph, opl} <= 2'b10;
        repeat (4) @(posedge clk_i);
        chk(pwoe, 24'hff_ffff);
        chk(pwo, opa_m);
        {oph, opl} <= 2'b01;
        @(posedge clk_i);
        {oph, opl} <= 2'b10;
        repeat (4) @(posedge clk_i);
        chk(pwo, {opa_m[22:0], sa});
        {oph, opl} <= 2'b11;
        repeat (4) @(posedge clk_i);
        {oph, opl} <= 2'b00;
        for (i = 0; i < 8; i++) begin
            bus(1'b1, `CTRL_ADDR, 4'hf, (i >= 4) ? 32'h4 : 32'h0, q);
            case (i % 4)
                0: pd = opa_m;
                1: pd = opa_m ^ 24'h1;
                2: pd = opa_m ^ 24'h80_0000;
                default: pd = 24'($random(seed));
            endcase
            pdrv <= pd;
            hv = (i >= 4) ? int'($signed(opa_m)) : int'(opa_m);
            pv = (i >= 4) ? int'($signed(pd)) : int'(pd);
            e3 = {hv > pv, hv < pv, hv == pv};
            repeat (6) @(posedge clk_i);
            chk({gto, lto, eqo}, e3);
            chk({gtoe, ltoe, eqoe}, {~e3[0], ~e3[0], e3[0]});
            bus(1'b0, `STAT_ADDR, 4'hf, 32'h0, q);
            chk(q[6:4], {e3[0], e3[1], e3[2]});
        end
        $display("test slice done");
        print_verdict();
    end
endmodule // word_comparator_test
